// >>> design/branch_cond_eval.sv
module branch_cond_eval (
	// Condition select and flags
	input wire branch_pkg::cond_e cond_i,
	input wire logic [branch_pkg::FLAGS_W-1:0] flags_i,
	// Outcome
	output logic taken_o,
	output logic legal_o
);

	logic n_xor_v;

	assign n_xor_v = flags_i[branch_pkg::FLAG_N] ^ flags_i[branch_pkg::FLAG_V];

	always_comb begin
		taken_o = 1'b0;
		legal_o = 1'b1;
		case (cond_i)
			branch_pkg::branch_equal: taken_o = flags_i[branch_pkg::FLAG_Z];
			branch_pkg::branch_not_equal: taken_o = ~flags_i[branch_pkg::FLAG_Z];
			branch_pkg::branch_carry_set: taken_o = flags_i[branch_pkg::FLAG_C];
			branch_pkg::branch_carry_clear: taken_o = ~flags_i[branch_pkg::FLAG_C];
			branch_pkg::branch_same_or_higher: taken_o = ~flags_i[branch_pkg::FLAG_C];
			branch_pkg::branch_lower: taken_o = flags_i[branch_pkg::FLAG_C];
			branch_pkg::branch_minus: taken_o = flags_i[branch_pkg::FLAG_N];
			branch_pkg::branch_plus: taken_o = ~flags_i[branch_pkg::FLAG_N];
			branch_pkg::branch_signed_ge: taken_o = ~n_xor_v;
			branch_pkg::branch_signed_lt: taken_o = n_xor_v;
			branch_pkg::branch_halfcarry_set: taken_o = flags_i[branch_pkg::FLAG_H];
			branch_pkg::branch_halfcarry_clear: taken_o = ~flags_i[branch_pkg::FLAG_H];
			default: begin
				taken_o = 1'b0;
				legal_o = 1'b0;
			end
		endcase
	end

endmodule

// >>> design/branch_pkg.sv
package branch_pkg;

	// Status register flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam int FLAGS_W = 8;

	localparam int OFFSET_W = 7;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
	localparam logic [7:0] REG_SKIP_CNT = 8'h0C;
	localparam logic [7:0] REG_LAST_TARGET = 8'h10;

	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;
	localparam int STATUS_TAKEN_BIT = 0;

	// Reset values
	localparam logic CTRL_ENABLE_RST = 1'b1;
	localparam logic [15:0] CNT_RST = 16'h0000;

	// Cycles spent per outcome
	localparam int CYCLES_NOT_TAKEN = 1;
	localparam int CYCLES_TAKEN = 2;

	typedef enum logic [3:0] {
		branch_equal = 4'h0,
		branch_not_equal = 4'h1,
		branch_carry_set = 4'h2,
		branch_carry_clear = 4'h3,
		branch_same_or_higher = 4'h4,
		branch_lower = 4'h5,
		branch_minus = 4'h6,
		branch_plus = 4'h7,
		branch_signed_ge = 4'h8,
		branch_signed_lt = 4'h9,
		branch_halfcarry_set = 4'hA,
		branch_halfcarry_clear = 4'hB
	} cond_e;

	// Gray along idle -> redirect -> idle
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_REDIRECT = 2'h1
	} state_e;

	typedef struct packed {
		cond_e cond;
		logic [OFFSET_W-1:0] offset;
	} branch_req_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage

// >>> design/conditional_branch_unit.sv
// Behaviour
// - Taken branch loads program_counter with counter plus offset plus one.
// - Each branch completes in one or two clocks by outcome.
// - No status flag is ever written by a branch.
// - Equal branch taken exactly when zero flag set.
// - Not-equal branch taken exactly when zero flag clear.
// - Carry-set taken on carry one; carry-clear taken on carry zero.
// - Same-or-higher branch taken exactly when carry clear.
// - Lower branch taken exactly when carry set.
// - Minus branch taken exactly when negative flag set.
// - Plus branch taken exactly when negative flag clear.
// - Signed greater-or-equal taken when negative xor overflow is zero.
// - Signed less-than taken when negative xor overflow is one.
// - Half-carry-set branch taken exactly when half carry set.
// - Half-carry-clear branch taken exactly when half carry clear.
//
// Register access over APB and the placing of the registers are this design's own decisions.
module conditional_branch_unit #(
	parameter int PC_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Branch request
	input wire logic req_valid_i,
	input wire branch_pkg::branch_req_s req_i,
	input wire logic [PC_W-1:0] program_counter_i,
	output logic req_ready_o,
	// Status register
	input wire logic [branch_pkg::FLAGS_W-1:0] flags_i,
	output logic flags_we_o,
	// Program counter update
	output logic done_o,
	output logic taken_o,
	output logic program_counter_load_o,
	output logic [PC_W-1:0] program_counter_o,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);

	generate
		if (PC_W < 8 || PC_W > 32) begin : g_bad_width
			$error("PC_W must lie between 8 and 32");
		end
	endgenerate

	typedef struct packed {
		branch_pkg::state_e fsm;
		logic enable;
		logic done;
		logic taken;
		logic last_taken;
		logic pc_load;
		logic [PC_W-1:0] pc_out;
		logic [PC_W-1:0] target;
		logic [PC_W-1:0] last_target;
		logic [15:0] taken_cnt;
		logic [15:0] skip_cnt;
		logic [31:0] prdata;
	} state_s;

	state_s st;
	state_s next_st;

	branch_pkg::apb_req_s apb;
	logic cond_taken;
	logic cond_legal;
	logic accept;
	logic apb_setup;
	logic apb_write;
	logic addr_hit;

	function automatic logic [PC_W-1:0] sext_offset(input logic [branch_pkg::OFFSET_W-1:0] k);
		sext_offset = {{(PC_W - branch_pkg::OFFSET_W){k[branch_pkg::OFFSET_W-1]}}, k};
	endfunction

	function automatic logic [PC_W-1:0] branch_target(
		input logic [PC_W-1:0] pc,
		input logic [branch_pkg::OFFSET_W-1:0] k
	);
		logic [PC_W-1:0] one;
		one = {{(PC_W - 1){1'b0}}, 1'b1};
		branch_target = pc + sext_offset(k) + one;
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == branch_pkg::REG_CTRL) || (a == branch_pkg::REG_STATUS) ||
			(a == branch_pkg::REG_TAKEN_CNT) || (a == branch_pkg::REG_SKIP_CNT) ||
			(a == branch_pkg::REG_LAST_TARGET);
	endfunction

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	branch_cond_eval u_eval (
		.cond_i(req_i.cond),
		.flags_i(flags_i),
		.taken_o(cond_taken),
		.legal_o(cond_legal)
	);

	assign apb.psel = psel_i;
	assign apb.penable = penable_i;
	assign apb.pwrite = pwrite_i;
	assign apb.paddr = paddr_i;
	assign apb.pwdata = pwdata_i;

	// Only idle and enabled units take a request
	assign req_ready_o = st.enable && (st.fsm == branch_pkg::ST_IDLE);
	assign accept = req_valid_i && req_ready_o;

	assign apb_setup = apb.psel && !apb.penable;
	assign apb_write = apb.psel && apb.penable && apb.pwrite;
	assign addr_hit = known_addr(apb.paddr);

	// Read data is latched in setup, so the access phase never waits
	assign pready_o = 1'b1;
	assign pslverr_o = apb.psel && apb.penable && !addr_hit;
	assign prdata_o = st.prdata;

	assign flags_we_o = 1'b0;
	assign done_o = st.done;
	assign taken_o = st.taken;
	assign program_counter_load_o = st.pc_load;
	assign program_counter_o = st.pc_out;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.taken = 1'b0;
		next_st.pc_load = 1'b0;

		case (st.fsm)
			branch_pkg::ST_IDLE: begin
				if (accept) begin
					next_st.target = branch_target(program_counter_i, req_i.offset);
					if (cond_taken && cond_legal) begin
						next_st.fsm = branch_pkg::ST_REDIRECT;
					end else begin
						next_st.done = 1'b1;
						next_st.pc_out = program_counter_i + {{(PC_W - 1){1'b0}}, 1'b1};
						next_st.last_taken = 1'b0;
						next_st.skip_cnt = sat_inc(st.skip_cnt);
					end
				end
			end
			branch_pkg::ST_REDIRECT: begin
				next_st.fsm = branch_pkg::ST_IDLE;
				next_st.done = 1'b1;
				next_st.taken = 1'b1;
				next_st.pc_load = 1'b1;
				next_st.pc_out = st.target;
				next_st.last_taken = 1'b1;
				next_st.last_target = st.target;
				next_st.taken_cnt = sat_inc(st.taken_cnt);
			end
			default: begin
				next_st.fsm = branch_pkg::ST_IDLE;
			end
		endcase

		// Register writes; a write to the counters clears them
		if (apb_write) begin
			case (apb.paddr)
				branch_pkg::REG_CTRL: next_st.enable = apb.pwdata[branch_pkg::CTRL_ENABLE_BIT];
				branch_pkg::REG_TAKEN_CNT: next_st.taken_cnt = branch_pkg::CNT_RST;
				branch_pkg::REG_SKIP_CNT: next_st.skip_cnt = branch_pkg::CNT_RST;
				default: begin
				end
			endcase
		end

		if (apb_setup && !apb.pwrite) begin
			case (apb.paddr)
				branch_pkg::REG_CTRL:
					next_st.prdata = {31'h00000000, st.enable};
				branch_pkg::REG_STATUS:
					next_st.prdata = {30'h00000000, st.fsm != branch_pkg::ST_IDLE, st.last_taken};
				branch_pkg::REG_TAKEN_CNT:
					next_st.prdata = {16'h0000, st.taken_cnt};
				branch_pkg::REG_SKIP_CNT:
					next_st.prdata = {16'h0000, st.skip_cnt};
				branch_pkg::REG_LAST_TARGET:
					next_st.prdata = 32'(st.last_target);
				default:
					next_st.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			st <= '0;
			st.fsm <= branch_pkg::ST_IDLE;
			st.enable <= branch_pkg::CTRL_ENABLE_RST;
			st.taken_cnt <= branch_pkg::CNT_RST;
			st.skip_cnt <= branch_pkg::CNT_RST;
		end else begin
			st <= next_st;
		end
	end

endmodule

// >>> verification/branch_chk.sv
module branch_chk #(
	parameter int PC_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Watched ports
	input wire logic req_valid_i,
	input wire branch_pkg::branch_req_s req_i,
	input wire logic [PC_W-1:0] program_counter_i,
	input wire logic req_ready_o,
	input wire logic flags_we_o,
	input wire logic done_o,
	input wire logic taken_o,
	input wire logic program_counter_load_o,
	input wire logic [PC_W-1:0] program_counter_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [PC_W-1:0] k_ext;
	assign k_ext = PC_W'(signed'(req_i.offset));
	sequence acc_s;
		req_valid_i && req_ready_o;
	endsequence
	sequence redir_s;
		!req_ready_o ##1 (done_o && taken_o);
	endsequence
	AST_NO_FLAG_WR: assert property (!flags_we_o) else $error("flag write");
	AST_DONE_BOUND: assert property (acc_s |-> ##[1:2] done_o) else $error("no done");
	AST_TAKEN_TWO: assert property (acc_s ##1 !done_o |-> redir_s) else $error("redirect");
	AST_SKIP_ONE: assert property (done_o && !taken_o |-> $past(req_valid_i && req_ready_o))
		else $error("skip late");
	AST_LOAD: assert property (program_counter_load_o == (done_o && taken_o))
		else $error("load pulse");
	AST_SKIP_PC: assert property (done_o && !taken_o |->
		program_counter_o == PC_W'($past(program_counter_i) + 1)) else $error("skip pc");
	AST_TARGET_PC: assert property (done_o && taken_o |-> program_counter_o ==
		PC_W'($past(program_counter_i, 2) + $past(k_ext, 2) + 1)) else $error("target");
	AST_PC_HOLD: assert property (!done_o |-> $stable(program_counter_o))
		else $error("pc moved");
endmodule

bind conditional_branch_unit branch_chk #(.PC_W(PC_W)) u_branch_chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
	.program_counter_i(program_counter_i), .req_ready_o(req_ready_o), .flags_we_o(flags_we_o),
	.done_o(done_o), .taken_o(taken_o), .program_counter_load_o(program_counter_load_o),
	.program_counter_o(program_counter_o)
);

// >>> verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
		$display("BAD %0t %h %h", $time, a, b); end end
	logic clk, rstn, vld, psel, pen, pwr, rdy, fwe, done, tk, ld, prdy, perr, se, lt;
	branch_pkg::branch_req_s req;
	logic [15:0] pc, pco, ltg;
	logic [7:0] fl, pa;
	logic [31:0] pwd, prd, rd;
	logic [7:0] ft [3] = '{8'h00, 8'h2F, 8'h04};
	int fails, compares, nt;

	conditional_branch_unit u_conditional_branch_unit (
		.core_clk_i(clk), .rstn_i(rstn), .req_valid_i(vld), .req_i(req),
		.program_counter_i(pc), .req_ready_o(rdy), .flags_i(fl), .flags_we_o(fwe),
		.done_o(done), .taken_o(tk), .program_counter_load_o(ld), .program_counter_o(pco),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr)
	);

	task automatic final_report;
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// condition table; codes past 4'hB never branch
	function automatic logic exp_t(input logic [3:0] c, input logic [7:0] f);
		case (c)
			4'h0: return f[1];
			4'h1: return !f[1];
			4'h2, 4'h5: return f[0];
			4'h3, 4'h4: return !f[0];
			4'h6: return f[2];
			4'h7: return !f[2];
			4'h8: return !(f[2] ^ f[3]);
			4'h9: return f[2] ^ f[3];
			4'hA: return f[5];
			4'hB: return !f[5];
			default: return 1'b0;
		endcase
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		// Answer is taken at the access edge itself
		@(posedge clk);
		while (prdy !== 1'b1 && n < 8) begin
			n++;
			@(posedge clk);
		end
		if (prdy !== 1'b1) begin
			fails++;
			final_report;
		end
		rd = prd;
		se = perr;
		psel <= 0;
		pen <= 0;
	endtask

	task automatic br(input logic [3:0] c, input logic [6:0] k, input logic [15:0] p,
		input logic [7:0] f);
		int n;
		logic t;
		logic [15:0] e;
		t = exp_t(c, f);
		e = t ? p + {{9{k[6]}}, k} + 16'h0001 : p + 16'h0001;
		nt += t;
		lt = t;
		if (t) ltg = e;
		@(posedge clk);
		vld <= 1;
		req <= '{branch_pkg::cond_e'(c), k};
		pc <= p;
		fl <= f;
		@(negedge clk);
		`CHK(rdy, 1'b1)
		@(posedge clk);
		vld <= 0;
		n = 0;
		@(negedge clk);
		while (done !== 1'b1 && n < 4) begin
			n++;
			@(negedge clk);
		end
		if (n > 3) begin
			fails++;
			final_report;
		end
		`CHK(n[1:0], {1'b0, t})
		`CHK(tk, t)
		`CHK(pco, e)
		`CHK(ld, t)
		`CHK(fwe, 1'b0)
	endtask

	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	initial begin
		rstn = 0;
		vld = 0;
		req = '0;
		pc = '0;
		fl = '0;
		psel = 0;
		pen = 0;
		pwr = 0;
		pa = '0;
		pwd = '0;
		lt = 0;
		ltg = '0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		apb(0, branch_pkg::REG_CTRL, 0);
		`CHK(rd[0], 1'b1)
		for (int c = 0; c < 14; c++) begin
			for (int i = 0; i < 3; i++) begin
				br(c[3:0], 7'(c * 37 + i * 19), 16'(c * 4951 + i), ft[i]);
			end
		end
		apb(0, branch_pkg::REG_TAKEN_CNT, 0);
		`CHK(rd, 32'(nt))
		apb(0, branch_pkg::REG_SKIP_CNT, 0);
		`CHK(rd, 32'(42 - nt))
		br(4'h0, 7'h40, 16'h0100, 8'h02);
		apb(0, branch_pkg::REG_STATUS, 0);
		`CHK(rd, 32'(lt))
		apb(0, branch_pkg::REG_LAST_TARGET, 0);
		`CHK(rd, 32'(ltg))
		// Mid-run reset must clear the PC output, status and taken counter
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		apb(0, branch_pkg::REG_STATUS, 0);
		`CHK(rd, 32'h00000000)
		apb(0, branch_pkg::REG_TAKEN_CNT, 0);
		`CHK(rd, 32'h00000000)
		`CHK(pco, 16'h0000)
		// Disabled unit must refuse requests
		apb(1, branch_pkg::REG_CTRL, 0);
		@(negedge clk);
		`CHK(rdy, 1'b0)
		apb(1, branch_pkg::REG_CTRL, 1);
		apb(0, 8'h14, 0);
		`CHK({se, rd}, 33'h1_0000_0000)
		final_report;
	end
endmodule
